//--- bench/spindle_model.sv
// Far-side model: spindle sensors and servo detectors
module spindle_model (
  // Clock
  input wire logic pclk,
  // Sensor lines toward the block
  output logic index_pulse,
  output logic [2:0] hall,
  output logic on_peak,
  output logic track_zero_det
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Sensor lines
  // ----------------------------------------
  initial begin
    index_pulse = 1'b0;
    hall = 3'h1;
    on_peak = 1'b0;
    track_zero_det = 1'b0;
  end
  // Wider than the 3-cycle minimum, so the synchroniser sees it
  task automatic pulse_index();
    @(posedge pclk) index_pulse <= 1'b1;
    repeat (6) @(posedge pclk);
    index_pulse <= 1'b0;
  endtask
  task automatic set_hall(input logic [2:0] h);
    @(posedge pclk) hall <= h;
  endtask
  task automatic peaks(input int n);
    repeat (n) begin
      @(posedge pclk) on_peak <= 1'b1;
      repeat (4) @(posedge pclk);
      on_peak <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic set_tz(input logic v);
    @(posedge pclk) track_zero_det <= v;
  endtask
endmodule // spindle_model

//--- bench/test_spindle_servo_control_sequencer.sv
// Self-checking bench for the spindle and servo control sequencer
`include "ssc_cfg.svh"
module test_spindle_servo_control_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, velocity_cmd;
  logic [31:0] pwdata, prdata, rd;
  logic ctrl_clk, mix_hi_clk, mix_lo_clk, chk_ref_clk, reg_ref_clk;
  logic index_pulse, on_peak, track_zero_det, irq;
  logic [2:0] hall, phase_drive;
  logic spindle_halt, brake_relay, speed_regulation_enable, lock_release;
  logic velocity_mode_sel, slope_polarity_sel, current_polarity_sel;
  logic power_amp_enable, track_zero_out, track_zero_out_oe;
  int num_errors = 0;
  int n_tests = 0;
  wire [3:0] refs = {chk_ref_clk, mix_lo_clk, mix_hi_clk, ctrl_clk};
  spindle_servo_control_sequencer uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl_clk,
    .mix_hi_clk, .mix_lo_clk, .chk_ref_clk, .reg_ref_clk, .index_pulse,
    .hall, .spindle_halt, .brake_relay, .speed_regulation_enable,
    .phase_drive, .lock_release, .on_peak, .track_zero_det,
    .velocity_mode_sel, .velocity_cmd, .slope_polarity_sel,
    .current_polarity_sel, .power_amp_enable, .track_zero_out,
    .track_zero_out_oe, .irq);
  spindle_model u_model (.pclk, .index_pulse, .hall, .on_peak,
    .track_zero_det);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // No wait-state count assumed; only the bound cuts a stuck access
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "pready never came");
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset();
    chk(spindle_halt, 1'b0, "halt after reset");
    chk(speed_regulation_enable, 1'b0, "regulation");
    chk(lock_release, 1'b0, "lock early");
    chk(power_amp_enable, 1'b0, "amp early");
    chk(irq, 1'b0, "irq at reset");
    apb(1'b0, `SSC_STAT_OFF, 32'h0);
    chk(rd[10:8], 3'b001, "state after reset");
    apb(1'b0, `SSC_CTRL_OFF, 32'h0);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, `SSC_MASK_OFF, 32'h0);
    chk(rd, 32'h0, "mask reset");
  endtask
  task t_refs();
    int n;
    int hp[4];
    logic v;
    hp = '{6, 54, 108, 678};
    chk(reg_ref_clk, 1'b1, "slow reference first half");
    for (int k = 0; k < 4; k++) begin
      n = 0;
      @(negedge pclk);
      v = refs[k];
      do begin
        @(negedge pclk);
        n++;
      end while (refs[k] === v && n < 2000);
      n = 0;
      v = refs[k];
      do begin
        @(negedge pclk);
        n++;
      end while (refs[k] === v && n < 2000);
      chk(n, hp[k], "reference half period");
    end
  endtask
  task t_hall();
    for (int h = 1; h < 7; h++) begin
      u_model.set_hall(h[2:0]);
      cyc(5);
      chk($onehot(phase_drive), 1'b1, "phase not one-hot");
    end
  endtask
  task t_servo();
    apb(1'b1, `SSC_VEL_OFF, 32'ha5);
    apb(1'b1, `SSC_CTRL_OFF, 32'h0c);
    cyc(2);
    chk(velocity_mode_sel, 1'b1, "seek mode");
    chk(velocity_cmd, 8'ha5, "velocity in seek");
    chk(slope_polarity_sel, 1'b1, "slope set");
    chk(current_polarity_sel, 1'b0, "current clear");
    apb(1'b1, `SSC_CTRL_OFF, 32'h30);
    cyc(2);
    chk(velocity_mode_sel, 1'b0, "follow mode");
    chk(velocity_cmd, 8'h00, "velocity in follow");
    chk(slope_polarity_sel, 1'b0, "slope clear");
    chk(current_polarity_sel, 1'b1, "current set");
    chk(power_amp_enable, 1'b0, "amp before speed");
  endtask
  task t_cross();
    apb(1'b1, `SSC_CTRL_OFF, 32'h04);
    u_model.peaks(5);
    cyc(4);
    apb(1'b0, `SSC_XCNT_OFF, 32'h0);
    chk(rd, 32'h5, "crossing count");
    apb(1'b1, `SSC_CTRL_OFF, 32'h0);
    cyc(2);
    apb(1'b0, `SSC_XCNT_OFF, 32'h0);
    chk(rd, 32'h0, "count cleared");
  endtask
  // Interval far below nominal: speed must not be reported good
  task t_index();
    u_model.pulse_index();
    cyc(300);
    u_model.pulse_index();
    cyc(10);
    chk(lock_release, 1'b0, "lock too fast");
    chk(speed_regulation_enable, 1'b0, "regulation too fast");
    apb(1'b0, `SSC_STAT_OFF, 32'h0);
    chk(rd[0], 1'b0, "nominal too fast");
    chk(rd[1], 1'b0, "count still pending");
  endtask
  task t_halt();
    apb(1'b1, `SSC_CTRL_OFF, 32'h1);
    cyc(3);
    chk(spindle_halt, 1'b1, "halt");
    chk(brake_relay, 1'b1, "brake");
    chk(phase_drive, 3'b000, "drive off");
    apb(1'b0, `SSC_STAT_OFF, 32'h0);
    chk(rd[10:8], 3'b100, "halt state");
    apb(1'b1, `SSC_CTRL_OFF, 32'h2);
    cyc(3);
    chk(spindle_halt, 1'b0, "restart");
  endtask
  task t_tzero();
    u_model.set_tz(1'b1);
    cyc(5);
    chk(track_zero_out_oe, 1'b1, "zero line driven");
    chk(track_zero_out, 1'b0, "zero line level");
    chk(irq, 1'b0, "masked irq");
    apb(1'b1, `SSC_MASK_OFF, 32'h4);
    cyc(2);
    chk(irq, 1'b1, "unmasked irq");
    apb(1'b0, `SSC_IRQ_OFF, 32'h0);
    chk(rd[2:0], 3'b100, "zero event");
    cyc(2);
    chk(irq, 1'b0, "irq after clear");
    u_model.set_tz(1'b0);
    cyc(5);
    chk(track_zero_out_oe, 1'b0, "zero line released");
  endtask
  task t_bus();
    apb(1'b0, 8'h1c, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, `SSC_STAT_OFF, 32'hffff);
    apb(1'b0, `SSC_STAT_OFF, 32'h0);
    chk(err, 1'b0, "mapped error");
    chk(rd[10:8], 3'b001, "status read only");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    t_reset();
    t_refs();
    t_hall();
    t_servo();
    t_cross();
    t_index();
    t_halt();
    t_tzero();
    t_bus();
    complete_run();
  end
  initial begin
    #(40000 * 8);
    num_errors++;
    $display("MISMATCH t=%0t run did not finish", $time);
    complete_run();
  end
endmodule // test_spindle_servo_control_sequencer

//--- design/spindle_servo_control_sequencer.sv
// Spindle start, regulation, braking and actuator servo control
// ----------------------------------------
// Contract
// - Controller, mixer and slow clocks count down from one oscillator.
// - Mixer-low and speed-checker references also count down from it.
// - After reset release, spindle_halt drops and regulation stays off.
// - Regulation turns on only once index interval is within one percent.
// - Regulator compares slow reference with Hall signal to hold speed.
// - Lookup commutator maps Hall code to one motor phase output.
// - spindle_halt drives brake relay and kills the three-phase drive.
// - lock_release rises only after spindle_nominal is true.
// - Checker times index interval on its reference, reports two flags.
// - Speed out of range while running shuts drive operation down.
// - velocity_mode_sel chooses seek or track-follow servo mode.
// - Seek mode presents an 8-bit velocity command.
// - slope_polarity_sel picks the negative-feedback slope.
// - current_polarity_sel picks amplifier current polarity for tachometer.
// - On-peak pulses during seek are counted as track crossings.
// - Amplifier delivers current only while power_amp_enable is high.
// - Detected track zero is reported and drives track_zero_out.
// ----------------------------------------
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "ssc_cfg.svh"

module spindle_servo_control_sequencer #(
  parameter int CNT_W = 16
) (
  // Clock and power-good reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference clocks
  output logic ctrl_clk,
  output logic mix_hi_clk,
  output logic mix_lo_clk,
  output logic chk_ref_clk,
  output logic reg_ref_clk,
  // Spindle
  input wire logic index_pulse,
  input wire logic [2:0] hall,
  output logic spindle_halt,
  output logic brake_relay,
  output logic speed_regulation_enable,
  output logic [2:0] phase_drive,
  output logic lock_release,
  // Actuator servo
  input wire logic on_peak,
  input wire logic track_zero_det,
  output logic velocity_mode_sel,
  output logic [7:0] velocity_cmd,
  output logic slope_polarity_sel,
  output logic current_polarity_sel,
  output logic power_amp_enable,
  // Open-drain track zero line
  output logic track_zero_out,
  output logic track_zero_out_oe,
  // Interrupt
  output logic irq
);
  import ssc_pkg::*;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [4:0][23:0] HALF = {
    24'(`SSC_OSC_HZ / (2 * `SSC_REG_HZ)),
    24'(`SSC_OSC_HZ / (2 * `SSC_CHK_HZ)),
    24'(`SSC_OSC_HZ / (2 * `SSC_MIXL_HZ)),
    24'(`SSC_OSC_HZ / (2 * `SSC_MIXH_HZ)),
    24'(`SSC_OSC_HZ / (2 * `SSC_CPU_HZ))};
  localparam int NOM = `SSC_CHK_HZ * 60 / `SSC_RPM;
  localparam logic [CNT_W-1:0] LO =
    CNT_W'(NOM * (100 - `SSC_TOL_PCT) / 100);
  localparam logic [CNT_W-1:0] HI =
    CNT_W'(NOM * (100 + `SSC_TOL_PCT) / 100);

  ssc_state_s s, n;
  logic [4:0] tick;
  logic wr, rd, mapped;
  logic idx_rise, hall_rise, pk_rise, tz_rise;
  logic [2:0] comm;
  logic accel, fault, ev_speed;

  // ----------------------------------------
  // Commutation table
  // ----------------------------------------
  always_comb begin
    case (s.hall_s2)
      3'b001: comm = 3'b001;
      3'b011: comm = 3'b010;
      3'b010: comm = 3'b010;
      3'b110: comm = 3'b100;
      3'b100: comm = 3'b100;
      3'b101: comm = 3'b001;
      default: comm = 3'b000;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    wr = psel & penable & pwrite;
    rd = psel & penable & ~pwrite;
    mapped = (paddr == `SSC_CTRL_OFF) || (paddr == `SSC_VEL_OFF)
      || (paddr == `SSC_STAT_OFF) || (paddr == `SSC_PERIOD_OFF)
      || (paddr == `SSC_XCNT_OFF) || (paddr == `SSC_IRQ_OFF)
      || (paddr == `SSC_MASK_OFF);
    // Count-down dividers, one oscillator for all
    for (int i = 0; i < 5; i++) begin
      tick[i] = 1'b0;
      if (s.div[i] == 24'h000000) begin
        n.div[i] = HALF[i] - 24'h000001;
        n.ck[i] = ~s.ck[i];
        tick[i] = ~s.ck[i];
      end else begin
        n.div[i] = s.div[i] - 24'h000001;
      end
    end
    // Synchronisers; edges only from second stage onward
    n.idx_s1 = index_pulse;
    n.idx_s2 = s.idx_s1;
    n.idx_p = s.idx_s2;
    n.hall_s1 = hall;
    n.hall_s2 = s.hall_s1;
    n.hall_p = s.hall_s2[0];
    n.pk_s1 = on_peak;
    n.pk_s2 = s.pk_s1;
    n.pk_p = s.pk_s2;
    n.tz_s1 = track_zero_det;
    n.tz_s2 = s.tz_s1;
    n.tz_p = s.tz_s2;
    idx_rise = s.idx_s2 & ~s.idx_p;
    hall_rise = s.hall_s2[0] & ~s.hall_p;
    pk_rise = s.pk_s2 & ~s.pk_p;
    tz_rise = s.tz_s2 & ~s.tz_p;
    // Index interval timing; saturates, never wraps
    if (tick[3] && s.spd_cnt != {CNT_W{1'b1}}) begin
      n.spd_cnt = s.spd_cnt + 16'h0001;
    end
    if (s.spd_cnt > HI) begin
      n.nominal = 1'b0;
    end
    if (idx_rise) begin
      n.spd_cnt = 16'h0000;
      n.seen = 1'b1;
      if (s.seen) begin
        n.period = s.spd_cnt;
        n.pending = 1'b0;
        n.nominal = (s.spd_cnt >= LO) && (s.spd_cnt <= HI);
      end
    end
    // Phase-frequency compare, saturating up/down
    if (tick[4] && !hall_rise && s.pfd != 4'h7) begin
      n.pfd = s.pfd + 4'h1;
    end else if (hall_rise && !tick[4] && s.pfd != 4'h8) begin
      n.pfd = s.pfd - 4'h1;
    end
    accel = ~s.pfd[3] && (s.pfd != 4'h0);
    // Track crossings, cleared while following
    if (!s.ctl[`SSC_C_SEEK]) begin
      n.xcnt = 16'h0000;
    end else if (pk_rise) begin
      n.xcnt = s.xcnt + 16'h0001;
    end
    // Sequencer
    fault = 1'b0;
    ev_speed = 1'b0;
    n.ctl[`SSC_C_RESTART] = 1'b0;
    case (s.st)
      ST_SPINUP: begin
        if (s.ctl[`SSC_C_STOP]) begin
          n.st = ST_HALT;
        end else if (s.nominal) begin
          n.st = ST_RUN;
          ev_speed = 1'b1;
        end
      end
      ST_RUN: begin
        if (!s.nominal && !s.pending) begin
          n.st = ST_HALT;
          fault = 1'b1;
        end else if (s.ctl[`SSC_C_STOP]) begin
          n.st = ST_HALT;
        end
      end
      ST_HALT: begin
        if (s.ctl[`SSC_C_RESTART] && !s.ctl[`SSC_C_STOP]) begin
          n.st = ST_SPINUP;
        end
      end
      default: n.st = ST_HALT;
    endcase
    // Any fresh start needs two new index pulses
    if (s.st == ST_HALT) begin
      n.seen = 1'b0;
      n.pending = 1'b1;
      n.nominal = 1'b0;
    end
    // Register writes
    if (wr) begin
      if (paddr == `SSC_CTRL_OFF) begin
        n.ctl = pwdata[5:0];
      end else if (paddr == `SSC_VEL_OFF) begin
        n.vel = pwdata[7:0];
      end else if (paddr == `SSC_MASK_OFF) begin
        n.irq_mask = pwdata[2:0];
      end
    end
    // Read clears status; a same-cycle event survives
    if (rd && paddr == `SSC_IRQ_OFF) begin
      n.irq_st = 3'b000;
    end
    n.irq_st[`SSC_I_SPEED] = n.irq_st[`SSC_I_SPEED] | ev_speed;
    n.irq_st[`SSC_I_FAULT] = n.irq_st[`SSC_I_FAULT] | fault;
    n.irq_st[`SSC_I_TZERO] = n.irq_st[`SSC_I_TZERO] | tz_rise;
    // Read data captured in setup phase
    if (psel && !penable) begin
      n.rdata = 32'h00000000;
      if (paddr == `SSC_CTRL_OFF) begin
        n.rdata[5:0] = s.ctl;
      end else if (paddr == `SSC_VEL_OFF) begin
        n.rdata[7:0] = s.vel;
      end else if (paddr == `SSC_STAT_OFF) begin
        n.rdata[10:0] = {s.st, 2'b00, spindle_halt, s.tz_s2,
          lock_release, speed_regulation_enable, s.pending,
          s.nominal};
      end else if (paddr == `SSC_PERIOD_OFF) begin
        n.rdata[15:0] = s.period;
      end else if (paddr == `SSC_XCNT_OFF) begin
        n.rdata[15:0] = s.xcnt;
      end else if (paddr == `SSC_IRQ_OFF) begin
        n.rdata[2:0] = s.irq_st;
      end else if (paddr == `SSC_MASK_OFF) begin
        n.rdata[2:0] = s.irq_mask;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ST_SPINUP;
      s.ctl <= `SSC_CTRL_RST;
      s.vel <= `SSC_VEL_RST;
      s.pending <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.rdata;
  assign {reg_ref_clk, chk_ref_clk, mix_lo_clk, mix_hi_clk,
    ctrl_clk} = s.ck;
  assign spindle_halt = (s.st == ST_HALT);
  assign brake_relay = spindle_halt;
  assign speed_regulation_enable = (s.st == ST_RUN);
  // Unregulated full drive during spin-up; pulsed once regulating
  assign phase_drive = spindle_halt ? 3'b000 :
    (!speed_regulation_enable || accel) ? comm : 3'b000;
  assign lock_release = (s.st == ST_RUN);
  assign velocity_mode_sel = s.ctl[`SSC_C_SEEK];
  assign velocity_cmd = velocity_mode_sel ? s.vel : 8'h00;
  assign slope_polarity_sel = s.ctl[`SSC_C_SLOPE];
  assign current_polarity_sel = s.ctl[`SSC_C_CURR];
  // Coil stays dead while the arm is still locked
  assign power_amp_enable = s.ctl[`SSC_C_AMP] & lock_release;
  assign track_zero_out = 1'b0;
  assign track_zero_out_oe = s.tz_s2;
  assign irq = |(s.irq_st & s.irq_mask);

  // ----------------------------------------
  // Checks: spindle
  // ----------------------------------------
  a_spinup_no_reg: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.st == ST_SPINUP |-> !spindle_halt && !speed_regulation_enable)
    else $error("spin-up shows halt or regulation");
  a_spinup_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.st == ST_SPINUP |-> phase_drive == comm)
    else $error("spin-up drive not unregulated");
  a_reg_after_nom: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(speed_regulation_enable) |-> $past(s.nominal))
    else $error("regulation enabled off speed");
  a_nom_window: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(s.nominal)
      |-> $past(s.spd_cnt) >= LO && $past(s.spd_cnt) <= HI)
    else $error("nominal outside window");
  a_reg_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    speed_regulation_enable && !accel |-> phase_drive == 3'b000)
    else $error("drive while reference lags");
  a_comm_onehot: assert property (
    @(posedge pclk) disable iff (!presetn)
    phase_drive != 3'b000 |-> $onehot(phase_drive) && !spindle_halt)
    else $error("bad phase drive");
  a_halt_kills: assert property (
    @(posedge pclk) disable iff (!presetn)
    spindle_halt |-> brake_relay && phase_drive == 3'b000)
    else $error("halt without brake");
  a_lock_nominal: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(lock_release) |-> $past(s.nominal) && $past(s.st) == ST_SPINUP)
    else $error("lock released early");
  a_pending_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    idx_rise && s.seen && s.st != ST_HALT |=> !s.pending)
    else $error("pending not cleared");
  a_halt_rearm: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.st == ST_HALT |=> s.pending && !s.nominal && !s.seen)
    else $error("halt keeps old speed");
  a_speed_fault: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.st == ST_RUN && !s.nominal && !s.pending
      |=> spindle_halt && !power_amp_enable && s.irq_st[`SSC_I_FAULT])
    else $error("speed fault not handled");
  // Saturation keeps a stalled spindle from looking nominal
  a_cnt_no_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.spd_cnt == 16'hffff && !idx_rise |=> s.spd_cnt == 16'hffff)
    else $error("interval counter wrapped");

  // ----------------------------------------
  // Checks: references, servo and interrupt
  // ----------------------------------------
  a_ck_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.div[0] == 24'h000000 |=> ctrl_clk != $past(ctrl_clk))
    else $error("controller clock missed a toggle");
  a_ck_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.div[3] != 24'h000000 |=> $stable(chk_ref_clk))
    else $error("checker reference toggled early");
  a_vel_seek: assert property (
    @(posedge pclk) disable iff (!presetn)
    !velocity_mode_sel |-> velocity_cmd == 8'h00)
    else $error("velocity command in follow mode");
  a_xing_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    velocity_mode_sel && s.pk_s2 && !s.pk_p
      |=> s.xcnt == 16'($past(s.xcnt) + 16'h0001))
    else $error("crossing not counted");
  a_amp_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    power_amp_enable |-> s.st == ST_RUN && s.ctl[`SSC_C_AMP])
    else $error("amplifier on out of run");
  a_tz_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(s.tz_s2) |-> track_zero_out_oe ##1 s.irq_st[`SSC_I_TZERO])
    else $error("track zero not reported");
  a_tz_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    !s.tz_s2 |-> !track_zero_out_oe)
    else $error("track zero line held");
endmodule // spindle_servo_control_sequencer

//--- inc/ssc_cfg.svh
// Constants of the spindle and servo control sequencer
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSC_CTRL_OFF 8'h00
`define SSC_VEL_OFF 8'h04
`define SSC_STAT_OFF 8'h08
`define SSC_PERIOD_OFF 8'h0c
`define SSC_XCNT_OFF 8'h10
`define SSC_IRQ_OFF 8'h14
`define SSC_MASK_OFF 8'h18
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define SSC_C_STOP 0
`define SSC_C_RESTART 1
`define SSC_C_SEEK 2
`define SSC_C_SLOPE 3
`define SSC_C_CURR 4
`define SSC_C_AMP 5
`define SSC_CTRL_RST 6'h00
`define SSC_VEL_RST 8'h00
// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define SSC_I_SPEED 0
`define SSC_I_FAULT 1
`define SSC_I_TZERO 2
// ----------------------------------------
// Frequencies and timing
// ----------------------------------------
`define SSC_OSC_HZ 125000000
`define SSC_CPU_HZ 9216000
`define SSC_MIXH_HZ 1152000
`define SSC_MIXL_HZ 576000
`define SSC_CHK_HZ 92100
`define SSC_REG_HZ 360
`define SSC_RPM 3600
`define SSC_TOL_PCT 1
`endif

//--- inc/ssc_pkg.sv
// Types of the spindle and servo control sequencer
package ssc_pkg;
  typedef enum logic [2:0] {
    ST_SPINUP = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } ctl_state_e;

  typedef struct packed {
    logic [5:0] ctl;
    logic [7:0] vel;
    ctl_state_e st;
    logic [4:0][23:0] div;
    logic [4:0] ck;
    logic idx_s1, idx_s2, idx_p;
    logic [2:0] hall_s1, hall_s2;
    logic hall_p;
    logic pk_s1, pk_s2, pk_p;
    logic tz_s1, tz_s2, tz_p;
    logic [15:0] spd_cnt;
    logic [15:0] period;
    logic seen, nominal, pending;
    logic [3:0] pfd;
    logic [15:0] xcnt;
    logic [2:0] irq_st, irq_mask;
    logic [31:0] rdata;
  } ssc_state_s;
endpackage
